//--- bpwc_core.sv
// block-transfer pixel write control: instruction decode, status, pixel gating, line stepping
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module bpwc_core #(
  parameter int ADDR_W = 26,
  parameter int LINES_W = 16,
  parameter int AXI_AW = 20,
  parameter logic [6:0] OPC_SETUP = 7'h00,
  parameter logic [6:0] OPC_SETUP_MONO = 7'h11,
  parameter logic [6:0] OPC_PIXEL = 7'h24,
  parameter logic [6:0] OPC_SPAN = 7'h25,
  parameter logic [6:0] OPC_GLYPH = 7'h26,
  parameter logic [6:0] OPC_INLINE = 7'h31
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // axi4-lite write address
  input wire logic [AXI_AW-1:0] s_axi_awaddr_in,
  input wire logic [2:0] s_axi_awprot_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // axi4-lite write data and response
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read
  input wire logic [AXI_AW-1:0] s_axi_araddr_in,
  input wire logic [2:0] s_axi_arprot_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // instruction stream from the parser
  input wire logic instr_valid_in,
  input wire logic [31:0] instr_dw0_in,
  input wire logic [31:0] instr_dw1_in,
  input wire logic pat_load_valid_in,
  input wire logic [63:0] pat_load_data_in,
  input wire logic [23:0] exp_bg_color_in,
  input wire logic [23:0] exp_fg_color_in,
  // destination address write and start
  input wire logic dest_address_kickoff_reg_wr_in,
  input wire logic [ADDR_W-1:0] dest_address_kickoff_reg_in,
  input wire logic [LINES_W-1:0] dest_lines_in,
  // pixel operands
  input wire logic pix_valid_in,
  input wire logic pix_line_end_in,
  input wire logic [2:0] pix_col_in,
  input wire logic pix_src_bit_in,
  input wire logic [23:0] pix_src_color_in,
  input wire logic [23:0] pix_pat_color_in,
  input wire logic [23:0] pix_dst_color_in,
  // pixel result
  output logic pix_valid_out,
  output logic [23:0] pix_data_out,
  output logic pix_we_out,
  // fetch steering and engine state
  output logic src_fetch_out,
  output logic inline_src_out,
  output logic pat_fetch_out,
  output logic dest_read_back_flag_out,
  output logic [ADDR_W-1:0] dest_addr_out,
  output logic [2:0] pat_row_out,
  output logic busy_out
);
  // ************************************************************
  // opcode decode
  // ************************************************************
  // returns {glyph, span, pixel, setup, csrc, msrc, cpat, mpat}
  function automatic logic [7:0] decode_op(input logic [6:0] op, input logic setup_mono);
    logic [7:0] f;
    f = 8'h00;
    if (op == OPC_SETUP || op == OPC_SETUP_MONO) begin
      f[4] = 1'b1;
    end
    if (op == OPC_PIXEL) begin
      f[7:5] = 3'h1;
      f[0] = 1'b1;
    end
    if (op == OPC_SPAN) begin
      f[7:5] = 3'h2;
      f[1] = !setup_mono;
      f[0] = setup_mono;
    end
    if (op == OPC_GLYPH) begin
      f[7:5] = 3'h4;
      f[2] = 1'b1;
      f[1] = !setup_mono;
      f[0] = setup_mono;
    end
    if (op == OPC_INLINE) begin
      f[3] = 1'b1;
    end
    return f;
  endfunction

  function automatic logic [23:0] depth_mask(input logic [1:0] depth);
    logic [23:0] m;
    m = bpwc_pkg::MASK_24;
    if (depth == bpwc_pkg::DEPTH_8) begin
      m = bpwc_pkg::MASK_8;
    end
    if (depth == bpwc_pkg::DEPTH_16) begin
      m = bpwc_pkg::MASK_16;
    end
    return m;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  logic [31:0] opcode_status;
  logic [31:0] setup_control;
  logic [63:0] pattern;
  logic [LINES_W-1:0] lines_left;
  logic aw_held;
  logic w_held;

  // ************************************************************
  // instruction decode
  // ************************************************************
  wire logic [6:0] in_op = instr_dw0_in[bpwc_pkg::OPC_HI:bpwc_pkg::OPC_LO];
  wire logic in_setup_mono = (in_op == OPC_SETUP_MONO);
  wire logic cur_setup_mono = opcode_status[bpwc_pkg::ST_SETUP_MONO];
  wire logic next_setup_mono = (in_op == OPC_SETUP) ? 1'b0 : (in_setup_mono ? 1'b1 : cur_setup_mono);
  wire logic [7:0] in_flags = decode_op(in_op, next_setup_mono);
  wire logic in_setup = in_flags[4];
  wire logic [7:0] rop = setup_control[bpwc_pkg::SC_ROP_HI:bpwc_pkg::SC_ROP_LO];
  wire logic [7:0] next_rop = in_setup ? instr_dw1_in[bpwc_pkg::SC_ROP_HI:bpwc_pkg::SC_ROP_LO] : rop;
  // destination matters when the raster code output differs with the d bit
  wire logic rop_uses_dst = (((next_rop >> 1) ^ next_rop) & bpwc_pkg::ROP_D_ODD) != 8'h00;
  wire logic [2:0] in_trans = instr_dw0_in[bpwc_pkg::TRANS_HI:bpwc_pkg::TRANS_LO];
  wire logic in_draw = in_flags[7:5] != 3'h0;
  wire logic in_dst_cmp = in_trans[0] && in_trans[1];
  wire logic in_read_back = in_draw && (rop_uses_dst || in_dst_cmp);
  wire logic [31:0] next_status_word = {
    busy_out,
    1'b0,
    next_setup_mono,
    in_op,
    instr_dw0_in[bpwc_pkg::OPC_LO-1:bpwc_pkg::ST_PACKING],
    2'h0,
    in_flags[7:5],
    instr_dw0_in[bpwc_pkg::TRANS_HI:bpwc_pkg::DW0_KEEP_LO],
    in_read_back,
    in_flags[3:0]
  };

  // ************************************************************
  // latched controls
  // ************************************************************
  wire logic [2:0] trans_mode = opcode_status[bpwc_pkg::TRANS_HI:bpwc_pkg::TRANS_LO];
  wire logic [2:0] valign = opcode_status[bpwc_pkg::VALIGN_HI:bpwc_pkg::VALIGN_LO];
  wire logic f_csrc = opcode_status[bpwc_pkg::ST_CSRC];
  wire logic f_msrc = opcode_status[bpwc_pkg::ST_MSRC];
  wire logic f_cpat = opcode_status[bpwc_pkg::ST_CPAT];
  wire logic f_mpat = opcode_status[bpwc_pkg::ST_MPAT];
  wire logic solid = setup_control[bpwc_pkg::SC_SOLID];
  wire logic src_trans = setup_control[bpwc_pkg::SC_SRC_TRANS];
  wire logic pat_trans = setup_control[bpwc_pkg::SC_PAT_TRANS];
  wire logic src_sel = setup_control[bpwc_pkg::SC_SRC_SEL];
  wire logic [1:0] depth = setup_control[bpwc_pkg::SC_DEPTH_HI:bpwc_pkg::SC_DEPTH_LO];
  wire logic [13:0] pitch = setup_control[bpwc_pkg::SC_PITCH_HI:bpwc_pkg::SC_PITCH_LO];
  wire logic [23:0] mask = depth_mask(depth);
  wire logic [23:0] bg = exp_bg_color_in & mask;
  wire logic [23:0] fg = exp_fg_color_in & mask;

  // ************************************************************
  // per pixel operands
  // ************************************************************
  wire logic pat_bit_raw = pattern[{pat_row_out, pix_col_in}];
  wire logic pat_bit = solid ? 1'b0 : pat_bit_raw;
  wire logic [23:0] src_op = f_msrc ? (pix_src_bit_in ? fg : bg) : pix_src_color_in;
  wire logic [23:0] mono_pat_op = solid ? bg : (pat_bit ? fg : bg);
  wire logic [23:0] pat_op = f_mpat ? mono_pat_op : pix_pat_color_in;
  wire logic [23:0] dst_op = pix_dst_color_in & mask;
  wire logic src_kill = f_msrc && src_trans && !pix_src_bit_in;
  wire logic pat_kill = f_mpat && pat_trans && !pat_bit;
  wire logic [23:0] rop_result;
  wire logic trans_write;
  wire logic pix_take = pix_valid_in && busy_out;
  wire logic last_line = pix_line_end_in && (lines_left <= LINES_W'(1));
  wire logic [ADDR_W-1:0] pitch_ext = ADDR_W'($signed(pitch));
  wire logic [ADDR_W-1:0] next_dest_addr = dest_addr_out + pitch_ext;

  bpwc_rop #(
    .WIDTH(24)
  ) u_rop (
    .rop_in(rop),
    .pat_in(pat_op),
    .src_in(src_op),
    .dst_in(dst_op),
    .result_out(rop_result)
  );

  bpwc_trans_gate u_gate (
    .mode_in(trans_mode),
    .mask_in(mask),
    .bg_in(bg),
    .rop_result_in(rop_result & mask),
    .dst_in(dst_op),
    .write_out(trans_write)
  );

  // ************************************************************
  // instruction and setup registers
  // ************************************************************
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      opcode_status <= bpwc_pkg::OPCODE_STATUS_RESET;
      setup_control <= bpwc_pkg::SETUP_CONTROL_RESET;
      pattern <= 64'h0000000000000000;
    end else begin
      if (instr_valid_in) begin
        opcode_status <= next_status_word;
      end
      if (instr_valid_in && in_setup) begin
        setup_control <= instr_dw1_in;
      end
      if (pat_load_valid_in) begin
        pattern <= pat_load_data_in;
      end
    end
  end

  // ************************************************************
  // engine run state and line stepping
  // ************************************************************
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_out <= 1'b0;
      dest_addr_out <= '0;
      lines_left <= '0;
      pat_row_out <= 3'h0;
    end else begin
      if (dest_address_kickoff_reg_wr_in) begin
        busy_out <= 1'b1;
        dest_addr_out <= dest_address_kickoff_reg_in;
        lines_left <= dest_lines_in;
        pat_row_out <= valign;
      end else if (pix_take && pix_line_end_in) begin
        dest_addr_out <= next_dest_addr;
        lines_left <= lines_left - LINES_W'(1);
        pat_row_out <= pat_row_out + 3'h1;
        if (last_line) begin
          busy_out <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // pixel output and fetch steering
  // ************************************************************
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pix_valid_out <= 1'b0;
      pix_data_out <= 24'h000000;
      pix_we_out <= 1'b0;
      src_fetch_out <= 1'b0;
      inline_src_out <= 1'b0;
      pat_fetch_out <= 1'b0;
      dest_read_back_flag_out <= 1'b0;
    end else begin
      pix_valid_out <= pix_take;
      pix_data_out <= rop_result & mask;
      pix_we_out <= pix_take && trans_write && !src_kill && !pat_kill;
      src_fetch_out <= (f_csrc || f_msrc) && !src_sel;
      inline_src_out <= (f_csrc || f_msrc) && src_sel;
      pat_fetch_out <= f_cpat || (f_mpat && !solid);
      dest_read_back_flag_out <= opcode_status[bpwc_pkg::ST_READ_BACK];
    end
  end

  // ************************************************************
  // axi4-lite slave: registers are read only, writes answer slverr
  // ************************************************************
  wire logic aw_take = s_axi_awvalid_in && s_axi_awready_out;
  wire logic w_take = s_axi_wvalid_in && s_axi_wready_out;
  wire logic aw_have = aw_held || aw_take;
  wire logic w_have = w_held || w_take;
  wire logic ar_take = s_axi_arvalid_in && s_axi_arready_out;
  wire logic rd_status = s_axi_araddr_in == bpwc_pkg::OPCODE_STATUS_ADDR;
  wire logic rd_setup = s_axi_araddr_in == bpwc_pkg::SETUP_CONTROL_ADDR;
  wire logic [31:0] live_status = {busy_out, opcode_status[30:0]};
  wire logic [31:0] rd_word = rd_status ? live_status : (rd_setup ? setup_control : 32'h00000000);
  wire logic [1:0] rd_resp = (rd_status || rd_setup) ? bpwc_pkg::RESP_OKAY : bpwc_pkg::RESP_DECERR;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= bpwc_pkg::RESP_OKAY;
    end else begin
      if (aw_have && w_have && !s_axi_bvalid_out) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= bpwc_pkg::RESP_SLVERR;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready_out <= 1'b0;
        s_axi_wready_out <= 1'b0;
      end else begin
        if (aw_take) begin
          aw_held <= 1'b1;
          s_axi_awready_out <= 1'b0;
        end
        if (w_take) begin
          w_held <= 1'b1;
          s_axi_wready_out <= 1'b0;
        end
        if (s_axi_bvalid_out && s_axi_bready_in) begin
          s_axi_bvalid_out <= 1'b0;
          s_axi_awready_out <= 1'b1;
          s_axi_wready_out <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= bpwc_pkg::RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= rd_word;
        s_axi_rresp_out <= rd_resp;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end
endmodule

//--- bpwc_pkg.sv
// constants shared by the block-transfer pixel write control files
package bpwc_pkg;
  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [19:0] OPCODE_STATUS_ADDR = 20'h40000;
  localparam logic [19:0] SETUP_CONTROL_ADDR = 20'h40004;
  localparam logic [31:0] OPCODE_STATUS_RESET = 32'h00000000;
  localparam logic [31:0] SETUP_CONTROL_RESET = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ************************************************************
  // instruction dword 0 fields
  // ************************************************************
  localparam int OPC_HI = 28;
  localparam int OPC_LO = 22;
  localparam int DW0_KEEP_HI = 22;
  localparam int DW0_KEEP_LO = 5;
  localparam int TRANS_HI = 10;
  localparam int TRANS_LO = 8;
  localparam int VALIGN_HI = 7;
  localparam int VALIGN_LO = 5;
  // ************************************************************
  // status register bit positions
  // ************************************************************
  localparam int ST_BUSY = 31;
  localparam int ST_CLIP = 30;
  localparam int ST_SETUP_MONO = 29;
  localparam int ST_PACKING = 16;
  localparam int ST_GLYPH = 13;
  localparam int ST_SPAN = 12;
  localparam int ST_PIXEL = 11;
  localparam int ST_READ_BACK = 4;
  localparam int ST_CSRC = 3;
  localparam int ST_MSRC = 2;
  localparam int ST_CPAT = 1;
  localparam int ST_MPAT = 0;
  // ************************************************************
  // setup control dword fields
  // ************************************************************
  localparam int SC_SOLID = 31;
  localparam int SC_SRC_TRANS = 29;
  localparam int SC_PAT_TRANS = 28;
  localparam int SC_SRC_SEL = 27;
  localparam int SC_DEPTH_HI = 25;
  localparam int SC_DEPTH_LO = 24;
  localparam int SC_ROP_HI = 23;
  localparam int SC_ROP_LO = 16;
  localparam int SC_PITCH_HI = 13;
  localparam int SC_PITCH_LO = 0;
  localparam logic [1:0] DEPTH_8 = 2'h0;
  localparam logic [1:0] DEPTH_16 = 2'h1;
  localparam logic [1:0] DEPTH_24 = 2'h2;
  localparam logic [23:0] MASK_8 = 24'h0000ff;
  localparam logic [23:0] MASK_16 = 24'h00ffff;
  localparam logic [23:0] MASK_24 = 24'hffffff;
  localparam logic [7:0] ROP_D_ODD = 8'h55;
endpackage

//--- bpwc_rop.sv
// ternary raster operation over one colour word
`timescale 1ns/1ps
module bpwc_rop #(
  parameter int WIDTH = 24
) (
  // operands
  input wire logic [7:0] rop_in,
  input wire logic [WIDTH-1:0] pat_in,
  input wire logic [WIDTH-1:0] src_in,
  input wire logic [WIDTH-1:0] dst_in,
  // result
  output logic [WIDTH-1:0] result_out
);
  // ************************************************************
  // per bit lookup
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      assign result_out[gi] = rop_in[{pat_in[gi], src_in[gi], dst_in[gi]}];
    end
  endgenerate
endmodule

//--- bpwc_trans_gate.sv
// destination colour transparency write decision
`timescale 1ns/1ps
module bpwc_trans_gate (
  // controls
  input wire logic [2:0] mode_in,
  input wire logic [23:0] mask_in,
  // colours
  input wire logic [23:0] bg_in,
  input wire logic [23:0] rop_result_in,
  input wire logic [23:0] dst_in,
  // decision
  output logic write_out
);
  // ************************************************************
  // compare
  // ************************************************************
  wire logic [23:0] other = mode_in[1] ? dst_in : rop_result_in;
  wire logic same = ((bg_in ^ other) & mask_in) == 24'h000000;
  wire logic want_equal = mode_in[2];
  assign write_out = !mode_in[0] ? 1'b1 : (want_equal ? same : !same);
endmodule

//--- bpwc_spare_note_none.sv
// spare unit: no logic lives here
`timescale 1ns/1ps

//--- bpwc_monitor.sv
// assertion checker on the pixel write control ports
`timescale 1ns/1ps
module bpwc_monitor (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // register bus
  input wire logic [19:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  // instructions, kickoff, pixels
  input wire logic instr_valid_in,
  input wire logic [31:0] instr_dw0_in,
  input wire logic [31:0] instr_dw1_in,
  input wire logic dest_address_kickoff_reg_wr_in,
  input wire logic [25:0] dest_address_kickoff_reg_in,
  input wire logic pix_valid_in,
  input wire logic pix_line_end_in,
  input wire logic pix_valid_out,
  input wire logic pix_we_out,
  input wire logic [25:0] dest_addr_out,
  input wire logic [2:0] pat_row_out,
  input wire logic busy_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  logic [31:0] setup_dw;
  logic trans0;
  wire [6:0] opc = instr_dw0_in[28:22];
  wire kick = dest_address_kickoff_reg_wr_in;
  wire px = pix_valid_in && busy_out;
  wire ar = s_axi_arvalid_in && s_axi_arready_out;
  wire mapped = s_axi_araddr_in == 20'h40000 || s_axi_araddr_in == 20'h40004;
  wire [25:0] step = {{12{setup_dw[13]}}, setup_dw[13:0]};
  // shadow of the latched setup word, tracked from the stream itself
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      setup_dw <= 32'h0;
      trans0 <= 1'h0;
    end else if (instr_valid_in) begin
      trans0 <= instr_dw0_in[8];
      if (opc == 7'h00 || opc == 7'h11) begin
        setup_dw <= instr_dw1_in;
      end
    end
  end
  AST_WR_REFUSED: assert property (s_axi_bvalid_out |-> s_axi_bresp_out == 2'h2)
    else $error("write not refused");
  AST_UNMAPPED: assert property (ar && !mapped |=> s_axi_rresp_out == 2'h3 && s_axi_rdata_out == 32'h0)
    else $error("unmapped read answer wrong");
  AST_SETUP_READ: assert property (ar && s_axi_araddr_in == 20'h40004 |=> s_axi_rdata_out == $past(setup_dw))
    else $error("setup word readback wrong");
  AST_KICKOFF: assert property (kick |=> busy_out && dest_addr_out == $past(dest_address_kickoff_reg_in))
    else $error("kickoff not taken");
  AST_BUSY_HOLD: assert property (!busy_out && !kick |=> !busy_out)
    else $error("busy without kickoff");
  AST_PIX_ANSWER: assert property (px |=> pix_valid_out ##1 (!pix_valid_out || $past(px)))
    else $error("pixel answer missing");
  AST_NO_PIX: assert property (!px |=> !pix_valid_out)
    else $error("pixel answer without request");
  AST_PITCH_STEP: assert property (px && !kick && pix_line_end_in |=> dest_addr_out == $past(dest_addr_out) + $past(step))
    else $error("line step wrong");
  AST_ROW_STEP: assert property (px && !kick && pix_line_end_in |=> pat_row_out == $past(pat_row_out) + 3'h1)
    else $error("pattern row not stepped");
  AST_NO_TRANS: assert property (px && !trans0 && setup_dw[29:28] == 2'h0 |=> pix_we_out)
    else $error("pixel write suppressed");
  COV_LINE: cover property (px && pix_line_end_in);
  COV_SUPPRESS: cover property (pix_valid_out && !pix_we_out);
  COV_DECERR: cover property (ar && !mapped);
endmodule

//--- bpwc_parser_model.sv
// instruction parser stand-in feeding the block
`timescale 1ns/1ps
module bpwc_parser_model (
  // clock
  input wire logic mclk_in,
  // instruction stream
  output logic instr_valid_out,
  output logic [31:0] instr_dw0_out,
  output logic [31:0] instr_dw1_out,
  output logic pat_load_valid_out,
  output logic [63:0] pat_load_data_out
);
  initial begin
    instr_valid_out = 1'h0;
    instr_dw0_out = 32'h0;
    instr_dw1_out = 32'h0;
    pat_load_valid_out = 1'h0;
    pat_load_data_out = 64'h0;
  end
  // always a dword pair, so inline data is never odd
  task automatic send(input logic [6:0] opc, input logic [21:0] low, input logic [31:0] dw1);
    @(posedge mclk_in);
    instr_dw0_out <= {3'h2, opc, low};
    instr_dw1_out <= (dw1 | 32'h04000000) & 32'hbfff3fff;
    instr_valid_out <= 1'h1;
    @(posedge mclk_in);
    instr_valid_out <= 1'h0;
    instr_dw0_out <= ~instr_dw0_out;
    instr_dw1_out <= ~instr_dw1_out;
  endtask
  task automatic load_pat(input logic [63:0] p);
    @(posedge mclk_in);
    pat_load_data_out <= p;
    pat_load_valid_out <= 1'h1;
    @(posedge mclk_in);
    pat_load_valid_out <= 1'h0;
    pat_load_data_out <= ~p;
  endtask
endmodule

//--- test_blit_pixel_write_control.sv
// self-checking bench for the pixel write control block
`timescale 1ns/1ps
module test_blit_pixel_write_control;
  logic mclk_in = 1'h0, rst_b_in = 1'h0;
  logic [19:0] s_axi_awaddr_in = 20'h0, s_axi_araddr_in = 20'h0;
  logic [2:0] s_axi_awprot_in = 3'h0, s_axi_arprot_in = 3'h0, pix_col_in = 3'h0;
  logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
  logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0, pix_src_bit_in = 1'h0;
  logic [31:0] s_axi_wdata_in = 32'h0, instr_dw0_in, instr_dw1_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic instr_valid_in, pat_load_valid_in;
  logic [63:0] pat_load_data_in;
  logic [23:0] exp_bg_color_in = 24'h0, exp_fg_color_in = 24'h0, pix_src_color_in = 24'h0;
  logic [23:0] pix_pat_color_in = 24'h0, pix_dst_color_in = 24'h0, pix_data_out;
  logic dest_address_kickoff_reg_wr_in = 1'h0, pix_valid_in = 1'h0, pix_line_end_in = 1'h0;
  logic [25:0] dest_address_kickoff_reg_in = 26'h0, dest_addr_out;
  logic [15:0] dest_lines_in = 16'h0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic pix_valid_out, pix_we_out, src_fetch_out, inline_src_out, pat_fetch_out, dest_read_back_flag_out;
  logic [2:0] pat_row_out;
  logic busy_out;
  logic [24:0] exq[$];
  int bad_count = 0, check_count = 0;
  always #10 mclk_in = ~mclk_in;
  bpwc_core dut (.*);
  bpwc_parser_model par (.mclk_in(mclk_in), .instr_valid_out(instr_valid_in), .instr_dw0_out(instr_dw0_in),
    .instr_dw1_out(instr_dw1_in), .pat_load_valid_out(pat_load_valid_in), .pat_load_data_out(pat_load_data_in));
  task automatic end_sim;
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp_px(input logic [24:0] e);
    cmp({7'h0, pix_we_out, pix_data_out}, {7'h0, e});
  endtask
  // ************
  // bus and stream drivers
  // ************
  task automatic rd(input logic [19:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= 1'h1;
    do @(posedge mclk_in); while (s_axi_arready_out !== 1'h1);
    s_axi_arvalid_in <= 1'h0;
    do @(posedge mclk_in); while (s_axi_rvalid_out !== 1'h1);
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    s_axi_rready_in <= 1'h0;
  endtask
  task automatic wr(input logic [19:0] a, output logic [1:0] r);
    @(posedge mclk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= $urandom;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= 1'h1;
    do begin
      @(posedge mclk_in);
      if (s_axi_awready_out === 1'h1) s_axi_awvalid_in <= 1'h0;
      if (s_axi_wready_out === 1'h1) s_axi_wvalid_in <= 1'h0;
    end while (s_axi_bvalid_out !== 1'h1);
    r = s_axi_bresp_out;
    s_axi_bready_in <= 1'h0;
  endtask
  task automatic kick(input logic [25:0] a, input logic [15:0] n);
    @(posedge mclk_in);
    dest_address_kickoff_reg_in <= a;
    dest_lines_in <= n;
    dest_address_kickoff_reg_wr_in <= 1'h1;
    @(posedge mclk_in);
    dest_address_kickoff_reg_wr_in <= 1'h0;
  endtask
  task automatic pixel(input logic le, input logic [23:0] dst, input logic sb, input logic [24:0] e);
    @(posedge mclk_in);
    pix_valid_in <= 1'h1;
    pix_line_end_in <= le;
    pix_dst_color_in <= dst;
    pix_src_bit_in <= sb;
    pix_src_color_in <= 24'($urandom);
    pix_pat_color_in <= 24'($urandom);
    pix_col_in <= 3'($urandom);
    exq.push_back(e);
    @(posedge mclk_in);
    pix_valid_in <= 1'h0;
  endtask
  // oldest note against each pixel answer
  always @(posedge mclk_in) begin
    if (pix_valid_out === 1'h1) begin
      if (exq.size() == 0) cmp(32'h1, 32'h0);
      else cmp_px(exq.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    bad_count++;
    end_sim();
  end
  initial begin
    logic [31:0] d, dw1;
    logic [1:0] r;
    logic [23:0] bg, dst, res, m, cv;
    logic [25:0] a;
    logic we;
    void'($urandom(32'ha0cd));
    repeat (5) @(posedge mclk_in);
    rst_b_in <= 1'h1;
    rd(20'h40000, d, r);
    cmp(d, 32'h0);
    rd(20'h40004, d, r);
    cmp(d, 32'h0);
    rd(20'h40008, d, r);
    cmp({d[29:0], r}, 32'h3);
    wr(20'h40004, r);
    cmp({30'h0, r}, 32'h2);
    par.load_pat(64'h0);
    // every transparency code, every depth code, rop pattern xor destination
    for (int t = 0; t < 8; t++) begin
      dw1 = {6'h01, 2'(t), 8'h5a, 2'h0, 14'($urandom)};
      m = (t % 4 == 0) ? 24'hff : (t % 4 == 1) ? 24'hffff : 24'hffffff;
      bg = 24'($urandom);
      dst = ($urandom % 2) ? 24'($urandom) : (t[1] ? bg : 24'h0);
      res = (bg ^ dst) & m;
      cv = t[1] ? dst : res;
      we = !t[0] || (t[2] == (((bg ^ cv) & m) == 24'h0));
      exp_bg_color_in <= bg;
      par.send(7'h00, 22'h0, dw1);
      rd(20'h40004, d, r);
      cmp(d, dw1);
      par.send(7'h24, {5'h0, 1'(t), 5'h0, 3'(t), 3'(t), 5'h0}, 32'h0);
      rd(20'h40000, d, r);
      cmp(d, 32'h09000811 | (t[0] << 16) | (t << 8) | (t << 5));
      cmp({src_fetch_out, inline_src_out, pat_fetch_out, dest_read_back_flag_out}, 32'h3);
      a = 26'($urandom);
      kick(a, 16'h2);
      @(posedge mclk_in);
      cmp(pat_row_out, t);
      pixel(1'h1, dst, $urandom, {we, res});
      @(posedge mclk_in);
      cmp(dest_addr_out, 26'(a + {{12{dw1[13]}}, dw1[13:0]}));
      pixel(1'h1, dst, $urandom, {we, res});
      @(posedge mclk_in);
      cmp(busy_out, 1'h0);
    end
    // pattern then source transparency with a zero bit, rop copies destination
    for (int k = 0; k < 2; k++) begin
      dst = 24'($urandom);
      par.send(7'h00, 22'h0, k ? 32'h2caa0000 : 32'h14aa0000);
      par.send(k ? 7'h26 : 7'h24, 22'h0, 32'h0);
      kick(26'($urandom), 16'h1);
      pixel(1'h1, dst, 1'h0, {1'h0, 16'h0, dst[7:0]});
      cmp({src_fetch_out, inline_src_out, pat_fetch_out, dest_read_back_flag_out}, k ? 32'h7 : 32'h3);
    end
    repeat (4) @(posedge mclk_in);
    cmp(exq.size(), 32'h0);
    end_sim();
  end
endmodule
bind bpwc_core bpwc_monitor mon (.*);
